// >>> include/sdsb_cfg.svh
`ifndef SDSB_CFG_SVH
`define SDSB_CFG_SVH

// Signature and subcommand codes.
`define SDSB_SIG_LO 8'h4F
`define SDSB_SIG_HI 8'hC2
`define SDSB_FAIL_LO 8'hF4
`define SDSB_FAIL_HI 8'h2C
`define SDSB_SUB_READ 8'hD0
`define SDSB_SUB_STAT 8'hDA

// Fixed header words, little endian in the sector.
`define SDSB_VER 16'h0004
`define SDSB_VER2 16'h0002
`define SDSB_CAPS 16'h0003

// Sector byte positions.
`define SDSB_IDX_VER_LO 9'h000
`define SDSB_IDX_VER_HI 9'h001
`define SDSB_IDX_ATTR_FIRST 9'h002
`define SDSB_IDX_ATTR_LAST 9'h169
`define SDSB_IDX_CAPS_LO 9'h170
`define SDSB_IDX_CAPS_HI 9'h171
`define SDSB_IDX_VER2_LO 9'h182
`define SDSB_IDX_VER2_HI 9'h183
`define SDSB_IDX_COMMIT_FIRST 9'h184
`define SDSB_IDX_COMMIT_LAST 9'h187
`define SDSB_IDX_WLTHR_FIRST 9'h188
`define SDSB_IDX_WLTHR_LAST 9'h18B
`define SDSB_IDX_WL 9'h18C
`define SDSB_IDX_BBM 9'h18D
`define SDSB_IDX_CSUM 9'h1FF

// Attribute entry layout.
`define SDSB_OFF_ID 4'h0
`define SDSB_OFF_FLAG_LO 4'h1
`define SDSB_OFF_FLAG_HI 4'h2
`define SDSB_OFF_VALUE 4'h3
`define SDSB_OFF_RAW 4'h4
`define SDSB_OFF_LAST 4'hB

// Attribute slots that are populated.
`define SDSB_ENT_SPARE 5'h00
`define SDSB_ENT_ERASE 5'h01
`define SDSB_ENT_ECC 5'h02
`define SDSB_ENT_CORR 5'h03
`define SDSB_ENT_CRC 5'h04
`define SDSB_ENT_READS 5'h05

// Attribute identifiers and flags.
`define SDSB_ID_SPARE 8'hC4
`define SDSB_ID_ERASE 8'hE5
`define SDSB_ID_ECC 8'hCB
`define SDSB_ID_CORR 8'hCC
`define SDSB_ID_CRC 8'hC7
`define SDSB_ID_READS 8'hE8
`define SDSB_FLAGS_PREFAIL 16'h0003
`define SDSB_FLAGS_ADVISORY 16'h0002
`define SDSB_FIXED_VALUE 8'h64

`endif

// >>> include/sdsb_pkg.sv
package sdsb_pkg;

	typedef enum logic [1:0] {
		SDSB_IDLE = 2'b00,
		SDSB_XFER = 2'b01,
		SDSB_ENDC = 2'b11
	} sdsb_state_t;

	typedef struct packed {
		logic [7:0] feature;
		logic [7:0] cyl_lo;
		logic [7:0] cyl_hi;
	} sdsb_cmd_t;

	typedef struct packed {
		logic [7:0] spare_pct;
		logic [15:0] weak_init;
		logic [15:0] weak_cur;
		logic [15:0] drive_init;
		logic [15:0] drive_cur;
		logic [7:0] life_pct;
		logic [63:0] erase_total;
		logic [31:0] ecc_total;
		logic [31:0] ecc_corr;
		logic [31:0] crc_errs;
		logic [63:0] reads;
		logic [31:0] commit_cnt;
		logic [31:0] wl_thresh;
		logic wl_active;
		logic bbm_active;
	} sdsb_stats_t;

	typedef struct packed {
		logic erase_prefail;
		logic [7:0] spare_thr;
		logic [7:0] erase_thr;
	} sdsb_fact_t;

	typedef struct packed {
		sdsb_state_t st;
		logic cfg_ok;
		sdsb_fact_t fcfg;
		sdsb_stats_t snap;
		logic [8:0] idx;
		logic [4:0] ent;
		logic [3:0] off;
		logic [7:0] sum;
		logic [7:0] dat;
		logic vld;
		logic last;
		logic busy;
		logic done;
		logic err;
		logic [7:0] cyl_lo;
		logic [7:0] cyl_hi;
	} sdsb_regs_t;

endpackage

// >>> design/sdsb_attr_byte.sv
`timescale 1ns/1ns
`include "sdsb_cfg.svh"

module sdsb_attr_byte (
	input wire logic [4:0] ent,
	input wire logic [3:0] off,
	input wire sdsb_pkg::sdsb_stats_t snap,
	input wire sdsb_pkg::sdsb_fact_t fcfg,
	output logic [7:0] val
);
	import sdsb_pkg::*;

	logic [7:0] id;
	logic [15:0] flags;
	logic [7:0] value;
	logic [63:0] raw;
	logic [2:0] sel;

	always_comb begin
		id = 8'h00;
		flags = 16'h0000;
		value = 8'h00;
		raw = 64'h0000000000000000;
		case (ent)
		`SDSB_ENT_SPARE: begin
			id = `SDSB_ID_SPARE;
			flags = `SDSB_FLAGS_PREFAIL;
			value = snap.spare_pct;
			raw = {snap.drive_cur, snap.drive_init, snap.weak_cur, snap.weak_init};
		end
		`SDSB_ENT_ERASE: begin
			id = `SDSB_ID_ERASE;
			flags = fcfg.erase_prefail ? `SDSB_FLAGS_PREFAIL : `SDSB_FLAGS_ADVISORY;
			value = snap.life_pct;
			raw = snap.erase_total;
		end
		`SDSB_ENT_ECC: begin
			id = `SDSB_ID_ECC;
			flags = `SDSB_FLAGS_ADVISORY;
			value = `SDSB_FIXED_VALUE;
			raw = {32'h00000000, snap.ecc_total};
		end
		`SDSB_ENT_CORR: begin
			id = `SDSB_ID_CORR;
			flags = `SDSB_FLAGS_ADVISORY;
			value = `SDSB_FIXED_VALUE;
			raw = {32'h00000000, snap.ecc_corr};
		end
		`SDSB_ENT_CRC: begin
			id = `SDSB_ID_CRC;
			flags = `SDSB_FLAGS_ADVISORY;
			value = `SDSB_FIXED_VALUE;
			raw = {32'h00000000, snap.crc_errs};
		end
		`SDSB_ENT_READS: begin
			id = `SDSB_ID_READS;
			flags = `SDSB_FLAGS_ADVISORY;
			value = `SDSB_FIXED_VALUE;
			raw = snap.reads;
		end
		// Slots past the six defined attributes stay all zero.
		default: begin
			id = 8'h00;
		end
		endcase
	end

	assign sel = 3'(off - `SDSB_OFF_RAW);

	always_comb begin
		val = raw[{sel, 3'h0} +: 8];
		if (off == `SDSB_OFF_ID) begin
			val = id;
		end else if (off == `SDSB_OFF_FLAG_LO) begin
			val = flags[7:0];
		end else if (off == `SDSB_OFF_FLAG_HI) begin
			val = flags[15:8];
		end else if (off == `SDSB_OFF_VALUE) begin
			val = value;
		end
	end
endmodule

// >>> design/sdsb_top.sv
`timescale 1ns/1ns
`include "sdsb_cfg.svh"


module sdsb_top (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic cmd_start,
	input wire sdsb_pkg::sdsb_cmd_t cmd,
	input wire sdsb_pkg::sdsb_stats_t stats,
	input wire sdsb_pkg::sdsb_fact_t fact,
	input wire logic dat_ready,
	output logic [7:0] dat_byte,
	output logic dat_valid,
	output logic dat_last,
	output logic busy,
	output logic done,
	output logic err,
	output logic [7:0] cyl_lo_out,
	output logic [7:0] cyl_hi_out
);
	import sdsb_pkg::*;

	// Whole words, so that each half can be picked out by a part-select.
	localparam logic [15:0] SDSB_VER_W = `SDSB_VER;
	localparam logic [15:0] SDSB_VER2_W = `SDSB_VER2;
	localparam logic [15:0] SDSB_CAPS_W = `SDSB_CAPS;

	localparam sdsb_regs_t SDSB_RST = '{
		st: SDSB_IDLE,
		cfg_ok: 1'b0,
		fcfg: '0,
		snap: '0,
		idx: 9'h000,
		ent: 5'h00,
		off: 4'h0,
		sum: 8'h00,
		dat: 8'h00,
		vld: 1'b0,
		last: 1'b0,
		busy: 1'b0,
		done: 1'b0,
		err: 1'b0,
		cyl_lo: 8'h00,
		cyl_hi: 8'h00
	};

	sdsb_regs_t q_ff;
	sdsb_regs_t nxt_q;
	logic [7:0] attr_byte;
	logic [7:0] hdr_byte;
	logic in_attr;
	logic sig_ok;
	logic exceeded;
	logic slot_free;

	sdsb_attr_byte u_attr (
		.ent(q_ff.ent),
		.off(q_ff.off),
		.snap(q_ff.snap),
		.fcfg(q_ff.fcfg),
		.val(attr_byte)
	);

	assign sig_ok = (cmd.cyl_lo == `SDSB_SIG_LO) && (cmd.cyl_hi == `SDSB_SIG_HI);
	// Thresholds come from the factory copy, so the host cannot move them.
	assign exceeded = (stats.spare_pct < q_ff.fcfg.spare_thr) ||
		(stats.life_pct < q_ff.fcfg.erase_thr);
	assign in_attr = (q_ff.idx >= `SDSB_IDX_ATTR_FIRST) && (q_ff.idx <= `SDSB_IDX_ATTR_LAST);
	assign slot_free = !q_ff.vld || dat_ready;

	// Every byte not named below reads zero, which covers all reserved ranges.
	always_comb begin
		hdr_byte = 8'h00;
		if (in_attr) begin
			hdr_byte = attr_byte;
		end else if (q_ff.idx == `SDSB_IDX_VER_LO) begin
			hdr_byte = SDSB_VER_W[7:0];
		end else if (q_ff.idx == `SDSB_IDX_VER_HI) begin
			hdr_byte = SDSB_VER_W[15:8];
		end else if (q_ff.idx == `SDSB_IDX_CAPS_LO) begin
			hdr_byte = SDSB_CAPS_W[7:0];
		end else if (q_ff.idx == `SDSB_IDX_CAPS_HI) begin
			hdr_byte = SDSB_CAPS_W[15:8];
		end else if (q_ff.idx == `SDSB_IDX_VER2_LO) begin
			hdr_byte = SDSB_VER2_W[7:0];
		end else if (q_ff.idx == `SDSB_IDX_VER2_HI) begin
			hdr_byte = SDSB_VER2_W[15:8];
		end else if ((q_ff.idx >= `SDSB_IDX_COMMIT_FIRST) &&
			(q_ff.idx <= `SDSB_IDX_COMMIT_LAST)) begin
			hdr_byte = q_ff.snap.commit_cnt[{q_ff.idx[1:0], 3'h0} +: 8];
		end else if ((q_ff.idx >= `SDSB_IDX_WLTHR_FIRST) &&
			(q_ff.idx <= `SDSB_IDX_WLTHR_LAST)) begin
			hdr_byte = q_ff.snap.wl_thresh[{q_ff.idx[1:0], 3'h0} +: 8];
		end else if (q_ff.idx == `SDSB_IDX_WL) begin
			hdr_byte = {7'h00, q_ff.snap.wl_active};
		end else if (q_ff.idx == `SDSB_IDX_BBM) begin
			hdr_byte = {7'h00, q_ff.snap.bbm_active};
		end
	end

	always_comb begin
		nxt_q = q_ff;
		nxt_q.done = 1'b0;
		unique case (q_ff.st)
		SDSB_IDLE: begin
			if (!q_ff.cfg_ok) begin
				// Factory values are caught once after reset and then held.
				nxt_q.fcfg = fact;
				nxt_q.cfg_ok = 1'b1;
			end else if (cmd_start) begin
				nxt_q.cyl_lo = cmd.cyl_lo;
				nxt_q.cyl_hi = cmd.cyl_hi;
				nxt_q.err = 1'b0;
				if (!sig_ok) begin
					nxt_q.err = 1'b1;
					nxt_q.done = 1'b1;
				end else if (cmd.feature == `SDSB_SUB_READ) begin
					// The snapshot keeps the checksum consistent while counters move.
					nxt_q.snap = stats;
					nxt_q.idx = 9'h000;
					nxt_q.ent = 5'h00;
					nxt_q.off = 4'h0;
					nxt_q.sum = 8'h00;
					nxt_q.busy = 1'b1;
					nxt_q.st = SDSB_XFER;
				end else if (cmd.feature == `SDSB_SUB_STAT) begin
					if (exceeded) begin
						nxt_q.cyl_lo = `SDSB_FAIL_LO;
						nxt_q.cyl_hi = `SDSB_FAIL_HI;
					end
					nxt_q.done = 1'b1;
				end else begin
					nxt_q.err = 1'b1;
					nxt_q.done = 1'b1;
				end
			end
		end
		SDSB_XFER: begin
			if (slot_free) begin
				nxt_q.vld = 1'b1;
				if (q_ff.idx == `SDSB_IDX_CSUM) begin
					nxt_q.dat = 8'(8'h00 - q_ff.sum);
					nxt_q.last = 1'b1;
					nxt_q.st = SDSB_ENDC;
				end else begin
					nxt_q.dat = hdr_byte;
					nxt_q.sum = 8'(q_ff.sum + hdr_byte);
					nxt_q.idx = 9'(q_ff.idx + 9'h001);
					if (in_attr) begin
						if (q_ff.off == `SDSB_OFF_LAST) begin
							nxt_q.off = 4'h0;
							nxt_q.ent = 5'(q_ff.ent + 5'h01);
						end else begin
							nxt_q.off = 4'(q_ff.off + 4'h1);
						end
					end
				end
			end
		end
		SDSB_ENDC: begin
			if (dat_ready) begin
				nxt_q.vld = 1'b0;
				nxt_q.last = 1'b0;
				nxt_q.busy = 1'b0;
				nxt_q.done = 1'b1;
				nxt_q.st = SDSB_IDLE;
			end
		end
		default: begin
			nxt_q = SDSB_RST;
		end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			q_ff <= SDSB_RST;
		end else if (ce) begin
			q_ff <= nxt_q;
		end
	end

	assign dat_byte = q_ff.dat;
	assign dat_valid = q_ff.vld;
	assign dat_last = q_ff.last;
	assign busy = q_ff.busy;
	assign done = q_ff.done;
	assign err = q_ff.err;
	assign cyl_lo_out = q_ff.cyl_lo;
	assign cyl_hi_out = q_ff.cyl_hi;
endmodule

// >>> bench/sdsb_top_sva.sv
`timescale 1ns/1ns
module sdsb_chk (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic cmd_start,
	input wire sdsb_pkg::sdsb_cmd_t cmd,
	input wire sdsb_pkg::sdsb_stats_t stats,
	input wire sdsb_pkg::sdsb_fact_t fact,
	input wire logic dat_ready,
	input wire logic [7:0] dat_byte,
	input wire logic dat_valid,
	input wire logic dat_last,
	input wire logic busy,
	input wire logic done,
	input wire logic err,
	input wire logic [7:0] cyl_lo_out,
	input wire logic [7:0] cyl_hi_out
);
	import sdsb_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	logic armed_ff;
	sdsb_fact_t fq_ff;
	// The factory copy is caught at the first enabled edge after reset, as the block does.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			armed_ff <= 1'b0;
		end else if (ce && !armed_ff) begin
			armed_ff <= 1'b1;
			fq_ff <= fact;
		end
	end
	// Commands before the factory copy or in the cycle of done fall outside the contract.
	wire idle = ce && armed_ff && !busy && !done;
	wire hit = (stats.spare_pct < fq_ff.spare_thr) || (stats.life_pct < fq_ff.erase_thr);
	property p_rd;
		cmd_start && idle && cmd == 24'hD04FC2 |=> busy ##1 dat_valid && dat_byte == 8'h04;
	endproperty
	a_rd: assert property (p_rd) else $error("read start wrong");
	property p_hold;
		ce && dat_valid && !dat_ready |=> dat_valid && $stable(dat_byte);
	endproperty
	a_hold: assert property (p_hold) else $error("byte not held");
	property p_end;
		ce && dat_last && dat_ready |=> done && !busy && !dat_valid;
	endproperty
	a_end: assert property (p_end) else $error("sector end wrong");
	property p_lastv;
		dat_last |-> dat_valid && busy;
	endproperty
	a_lastv: assert property (p_lastv) else $error("last without valid");
	property p_sig;
		cmd_start && idle && (cmd.cyl_lo != 8'h4F || cmd.cyl_hi != 8'hC2) |=> done && err && !busy;
	endproperty
	a_sig: assert property (p_sig) else $error("bad signature accepted");
	property p_noxfer;
		err |-> !dat_valid && !busy;
	endproperty
	a_noxfer: assert property (p_noxfer) else $error("data sent on error");
	property p_stat;
		cmd_start && idle && cmd == 24'hDA4FC2 |=> done && !err &&
			({cyl_lo_out, cyl_hi_out} == ($past(hit) ? 16'hF42C : 16'h4FC2));
	endproperty
	a_stat: assert property (p_stat) else $error("status answer wrong");
	property p_dn;
		ce && done |=> !done;
	endproperty
	a_dn: assert property (p_dn) else $error("done too long");
	c_rd: cover property (dat_last && dat_ready);
	c_fail: cover property (done && cyl_lo_out == 8'hF4);
	c_err: cover property (done && err);
endmodule

bind sdsb_top sdsb_chk u_chk (.*);

// >>> bench/sdsb_host_model.sv
`timescale 1ns/1ns
module sdsb_host_model (
	input wire logic core_clk,
	input wire logic stall,
	input wire logic [7:0] dat_byte,
	input wire logic dat_valid,
	input wire logic dat_last,
	output logic dat_ready
);
	logic [7:0] mem [512];
	int cnt = 0;
	int last_at = -1;
	int ph = 0;
	initial dat_ready = 0;
	// Stalling two cycles in three keeps the holding path busy for the whole sector.
	always @(posedge core_clk) begin
		if (dat_valid && dat_ready) begin
			if (dat_last) begin
				last_at = cnt;
			end
			mem[cnt % 512] = dat_byte;
			cnt++;
		end
		ph++;
		#1 dat_ready <= !stall || ph % 3 == 0;
	end
endmodule

// >>> bench/tb_sdsb_top.sv
`timescale 1ns/1ns
module tb_sdsb_top;
	import sdsb_pkg::*;
	logic core_clk = 0, srst = 1, ce = 1, cmd_start = 0, stall = 1, dat_ready;
	sdsb_cmd_t cmd = '0;
	sdsb_fact_t fact = {1'b1, 8'h32, 8'h0A};
	sdsb_stats_t stats = {8'h28, 16'h0101, 16'h0202, 16'h0303, 16'h0404, 8'h5A,
		64'h1122334455667788, 32'hA1A2A3A4, 32'hB1B2B3B4, 32'hC1C2C3C4,
		64'hD1D2D3D4D5D6D7D8, 32'hE1E2E3E4, 32'hF1F2F3F4, 1'b1, 1'b0};
	logic [7:0] dat_byte, cyl_lo_out, cyl_hi_out;
	logic dat_valid, dat_last, busy, done, err;
	logic [7:0] exp [512];
	int err_total = 0, tests_run = 0;
	sdsb_top DUT (.core_clk, .srst, .ce, .cmd_start, .cmd, .stats, .fact, .dat_ready,
		.dat_byte, .dat_valid, .dat_last, .busy, .done, .err, .cyl_lo_out, .cyl_hi_out);
	sdsb_host_model HOST (.core_clk, .stall, .dat_byte, .dat_valid, .dat_last, .dat_ready);
	initial forever #50 core_clk = ~core_clk;
	task tick; @(posedge core_clk); #1; endtask
	task chk(string nm, logic [63:0] e, logic [63:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s exp %0h got %0h", nm, e, g);
		end
	endtask
	task issue(logic [23:0] c); cmd_start = 1; cmd = c; tick; cmd_start = 0; endtask
	task put(int i, logic [95:0] v, int n);
		for (int k = 0; k < n; k++) exp[i + k] = v[8 * k +: 8];
	endtask
	task ent(int k, logic [7:0] id, logic [15:0] fl, logic [7:0] v, logic [63:0] r);
		put(2 + 12 * k, {r, v, fl, id}, 12);
	endtask
	task t_read(logic [15:0] efl);
		logic [7:0] s;
		int n0;
		s = 0;
		n0 = HOST.cnt;
		foreach (exp[i]) exp[i] = 0;
		foreach (HOST.mem[i]) HOST.mem[i] = 'x;
		put(0, 16'h0004, 2);
		ent(0, 8'hC4, 16'h0003, stats.spare_pct,
			{stats.drive_cur, stats.drive_init, stats.weak_cur, stats.weak_init});
		ent(1, 8'hE5, efl, stats.life_pct, stats.erase_total);
		ent(2, 8'hCB, 16'h0002, 8'h64, stats.ecc_total);
		ent(3, 8'hCC, 16'h0002, 8'h64, stats.ecc_corr);
		ent(4, 8'hC7, 16'h0002, 8'h64, stats.crc_errs);
		ent(5, 8'hE8, 16'h0002, 8'h64, stats.reads);
		put(368, 16'h0003, 2);
		put(386, {stats.wl_thresh, stats.commit_cnt, 16'h0002}, 10);
		put(396, {7'h00, stats.bbm_active, 7'h00, stats.wl_active}, 2);
		for (int i = 0; i < 511; i++) s += exp[i];
		exp[511] = -s;
		issue(24'hD04FC2);
		for (int n = 0; n < 3000 && done !== 1'b1; n++) tick;
		chk("read done", 1, done);
		chk("count", 512, HOST.cnt - n0);
		chk("last at", n0 + 511, HOST.last_at);
		for (int i = 0; i < 512; i++) chk($sformatf("byte %0d", i), exp[i], HOST.mem[i]);
		chk("read err", 0, err);
	endtask
	task t_bad(logic [23:0] c);
		int n;
		n = HOST.cnt;
		tick;
		issue(c);
		chk("bad done", 1, done);
		chk("bad err", 1, err);
		repeat (4) tick;
		chk("bad count", n, HOST.cnt);
	endtask
	task t_stat(logic [7:0] sp, logic [7:0] lf, logic [15:0] e);
		stats.spare_pct = sp;
		stats.life_pct = lf;
		tick;
		issue(24'hDA4FC2);
		chk("stat done", 1, done);
		chk("stat err", 0, err);
		chk("stat cyl", e, {cyl_lo_out, cyl_hi_out});
	endtask
	task t_freeze;
		logic [15:0] c;
		tick;
		c = {cyl_lo_out, cyl_hi_out};
		ce = 0;
		issue(24'hD04FC2);
		repeat (3) tick;
		chk("frozen busy", 0, busy);
		chk("frozen done", 0, done);
		chk("frozen cyl", c, {cyl_lo_out, cyl_hi_out});
		ce = 1;
		tick;
		chk("thawed busy", 0, busy);
	endtask
	task t_rst;
		srst = 1;
		repeat (2) tick;
		srst = 0;
		chk("reset busy", 0, busy);
		chk("reset cyl", 0, {cyl_lo_out, cyl_hi_out});
		tick;
		tick;
	endtask
	task conclude;
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge core_clk);
		#1 srst = 0;
		tick;
		tick;
		t_read(16'h0003);
		t_bad(24'hD04FC3);
		t_bad(24'hD04EC2);
		t_bad(24'hD14FC2);
		t_stat(8'h28, 8'h5A, 16'hF42C);
		t_stat(8'h32, 8'h5A, 16'h4FC2);
		t_stat(8'h32, 8'h09, 16'hF42C);
		// The thresholds are latched once after reset, so this change must have no effect.
		fact = {1'b0, 8'hFF, 8'hFF};
		t_stat(8'h32, 8'h5A, 16'h4FC2);
		t_freeze;
		// A fresh reset catches the new factory values; the host now never stalls.
		t_rst;
		stall = 0;
		t_read(16'h0002);
		t_stat(8'h32, 8'h5A, 16'hF42C);
		conclude;
	end
	initial begin
		#1000000;
		err_total++;
		conclude;
	end
endmodule
